// >>> hdl/wake_timer_consts.svh
// Register indices, field positions, reset values and divider codes of the wake-up timer
`ifndef WAKE_TIMER_CONSTS_SVH
`define WAKE_TIMER_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_T3_COUNT_HIGH    8'h21
`define IDX_T3_COUNT_LOW     8'h22
`define IDX_CONTROL          8'h23
`define IDX_RELOAD_HIGH      8'h24
`define IDX_RELOAD_LOW       8'h25
`define IDX_COUNT_HIGH       8'h26
`define IDX_COUNT_LOW        8'h27
`define IDX_IRQ_STATUS       8'h30
`define IDX_IRQ_MASK         8'h31

// Control register fields
`define BIT_RUNNING          7
`define BIT_RUN_WRITE_EN     6
`define BIT_AUTO_TRIM        5
`define BIT_AUTO_CARD_DETECT 4
`define BIT_AUTO_RELOAD      3
`define BIT_AUTO_WAKE        2
`define CLK_SEL_MSB          1
`define CLK_SEL_LSB          0

// Interrupt status bits
`define IRQ_UNDERFLOW        0
`define IRQ_CARD_FOUND       1
`define IRQ_DETECT_EMPTY     2
`define IRQ_COUNT            3

// Reset values
`define CONTROL_RESET        6'h00
`define RELOAD_RESET         16'h0000
`define MASK_RESET           3'h0

// Clock select codes and prescaler terminal counts (divisor minus one)
`define CLK_SEL_DIV1         2'h0
`define CLK_SEL_DIV8         2'h1
`define CLK_SEL_DIV16        2'h2
`define CLK_SEL_DIV32        2'h3
`define TERM_DIV1            5'h00
`define TERM_DIV8            5'h07
`define TERM_DIV16           5'h0F
`define TERM_DIV32           5'h1F

`endif

// >>> hdl/wake_timer_pkg.sv
// Types shared by the wake-up timer modules
package wake_timer_pkg;
   typedef logic [15:0] count_t;
   typedef logic [1:0]  clock_select_t;
   typedef enum logic [1:0] {
      CD_IDLE,
      CD_FIELD,
      CD_RESULT
   } card_detect_state_t;
endpackage

// >>> hdl/tick_if.sv
// Interface between the timer core and its tick prescaler
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic [1:0] sel;
   logic       clear;
   logic       tick;
   modport ctrl  (output sel, output clear, input tick);
   modport presc (input sel, input clear, output tick);
endinterface
`default_nettype wire

// >>> hdl/tick_prescaler.sv
// Prescaler that turns oscillator ticks into wake-up timer ticks
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_consts.svh"
module tick_prescaler #(
   parameter int DIV_W = 5
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Oscillator tick, one cycle per oscillator period
   input  wire logic lfo_tick,
   // Control side
   tick_if.presc     tp
);
   import wake_timer_pkg::*;

   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic [DIV_W-1:0] term;
   logic             at_term;

   // Terminal count chosen by the clock select code
   assign term = (tp.sel == `CLK_SEL_DIV1)  ? `TERM_DIV1  :
                 (tp.sel == `CLK_SEL_DIV8)  ? `TERM_DIV8  :
                 (tp.sel == `CLK_SEL_DIV16) ? `TERM_DIV16 : `TERM_DIV32;
   assign at_term = (cnt_q >= term);
   assign tp.tick = lfo_tick & at_term;
   // Clear aligns the first tick to a full period after start
   assign cnt_d = tp.clear ? '0 :
                  !lfo_tick ? cnt_q :
                  at_term ? '0 : cnt_q + 1'b1;

   // Divider count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/wakeup_timer_block.sv
// Wake-up timer: down counter, event launch, card-detect sequencing and AHB-Lite registers
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_consts.svh"
module wakeup_timer_block (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // Low-frequency oscillator tick
   input  wire logic                   lfo_tick,
   // Third timer, owned elsewhere
   input  wire wake_timer_pkg::count_t third_timer_count,
   input  wire logic                   third_timer_underflow,
   // Card detection analog path and trimming engine
   input  wire logic                   card_result_valid,
   input  wire logic                   card_present,
   input  wire logic                   trim_done,
   // Requests to the rest of the chip
   output logic                        wake_up_req,
   output logic                        trim_start,
   output logic                        card_detect_start,
   output logic                        rf_field_enable,
   output logic                        power_down_req,
   // Interrupt
   output logic                        wake_timer_irq
);
   import wake_timer_pkg::*;

   // Register index decode, used by both the write and read paths
   function automatic logic is_reg(input logic [7:0] idx, input logic [7:0] want);
      is_reg = (idx == want);
   endfunction

   tick_if tck ();

   // Bus phase state
   logic [7:0]               idx_q;
   logic                     wr_pend_q;
   logic [31:0]              hrdata_q;
   logic [31:0]              rd_value;
   logic                     addr_take;
   logic [7:0]               addr_idx;

   // Control and data state
   logic                     running_q;
   logic                     running_d;
   logic [5:0]               cfg_q;
   logic [5:0]               cfg_d;
   count_t                   reload_q;
   count_t                   reload_d;
   count_t                   count_q;
   count_t                   count_d;
   logic [`IRQ_COUNT-1:0]    status_q;
   logic [`IRQ_COUNT-1:0]    status_d;
   logic [`IRQ_COUNT-1:0]    mask_q;
   logic [`IRQ_COUNT-1:0]    mask_d;
   logic [`IRQ_COUNT-1:0]    irq_event;
   logic [`IRQ_COUNT-1:0]    irq_clear;
   card_detect_state_t       cd_state_q;
   card_detect_state_t       cd_state_d;

   // Registered outputs
   logic                     wake_up_req_q;
   logic                     trim_start_q;
   logic                     card_detect_start_q;
   logic                     rf_field_q;
   logic                     power_down_req_q;
   logic                     irq_q;

   // Decoded writes
   logic                     wr_ctrl;
   logic                     wr_reload_hi;
   logic                     wr_reload_lo;
   logic                     wr_status;
   logic                     wr_mask;
   logic                     start_wr;
   logic                     stop_wr;

   // Counter events
   logic                     auto_trim;
   logic                     auto_card_detect;
   logic                     auto_reload;
   logic                     auto_wake;
   logic                     tick;
   logic                     at_zero;
   logic                     underflow;
   logic                     keep_counting;
   logic                     cd_launch;
   logic                     cd_found;
   logic                     cd_empty;

   // Hreadyout is tied high, so no transfer is ever stretched
   // Index bits above [9:2] are ignored; the map aliases every 1 KiB
   // Address phase is taken when selected, bus ready and transfer is NONSEQ or SEQ
   assign addr_take = hsel & hready & htrans[1];
   assign addr_idx  = haddr[9:2];

   // Write decode in the data phase; only word transfers are issued, so hsize is not checked
   assign wr_ctrl      = wr_pend_q & is_reg(idx_q, `IDX_CONTROL);
   assign wr_reload_hi = wr_pend_q & is_reg(idx_q, `IDX_RELOAD_HIGH);
   assign wr_reload_lo = wr_pend_q & is_reg(idx_q, `IDX_RELOAD_LOW);
   assign wr_status    = wr_pend_q & is_reg(idx_q, `IDX_IRQ_STATUS);
   assign wr_mask      = wr_pend_q & is_reg(idx_q, `IDX_IRQ_MASK);

   // A control write may change running only if it also sets the write-enable bit
   assign start_wr = wr_ctrl & hwdata[`BIT_RUN_WRITE_EN] & hwdata[`BIT_RUNNING];
   assign stop_wr  = wr_ctrl & hwdata[`BIT_RUN_WRITE_EN] & ~hwdata[`BIT_RUNNING];

   // Configuration fields
   assign auto_trim        = cfg_q[`BIT_AUTO_TRIM];
   assign auto_card_detect = cfg_q[`BIT_AUTO_CARD_DETECT];
   assign auto_reload      = cfg_q[`BIT_AUTO_RELOAD];
   assign auto_wake        = cfg_q[`BIT_AUTO_WAKE];

   // The divider sits in its own module so its width can change
   // without touching the register logic
   // Prescaler hookup; a start realigns the divider so the first period is whole
   assign tck.sel   = cfg_q[`CLK_SEL_MSB:`CLK_SEL_LSB];
   assign tck.clear = start_wr;
   assign tick      = tck.tick;

   tick_prescaler #(
      .DIV_W (5)
   ) u_prescaler (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .lfo_tick (lfo_tick),
      .tp       (tck.presc)
   );

   // Ticks while stopped are ignored and never move the count
   // Underflow is the tick that finds the counter at zero
   assign at_zero       = (count_q == 16'h0000);
   assign underflow     = running_q & tick & at_zero;
   // Card detection forces a gapless reload even without auto-reload
   assign keep_counting = auto_reload | auto_card_detect;

   // Reload N spans N+1 ticks: the tick finding zero is the underflow
   // A reload of zero thus underflows on every tick
   // Counter next value: start load beats underflow reload beats decrement
   assign count_d = start_wr                  ? reload_q :
                    underflow & keep_counting ? reload_q :
                    running_q & tick & !at_zero ? count_q - 16'h0001 :
                    count_q;

   // A stop write racing an underflow still lets the flag set,
   // so software may see one late interrupt after stopping
   // Running state; a stop write wins over the same-cycle underflow
   assign running_d = start_wr ? 1'b1 :
                      stop_wr ? 1'b0 :
                      (underflow & !keep_counting) ? 1'b0 : running_q;

   // Clock select changes act at once; the divider is not cleared,
   // so the first period after such a change may be short
   // Configuration bits take every control write; bits 7 and 6 are not stored here
   assign cfg_d = wr_ctrl ? hwdata[5:0] : cfg_q;

   // Bytes are written separately; a start or a reloading underflow copies the word,
   // so a half-written value can reach a counter that reloads
   // Reload bytes; a new value reaches the counter at the next start or reloading underflow
   assign reload_d = {wr_reload_hi ? hwdata[7:0] : reload_q[15:8],
                      wr_reload_lo ? hwdata[7:0] : reload_q[7:0]};

   assign mask_d = wr_mask ? hwdata[`IRQ_COUNT-1:0] : mask_q;

   // Dropping a busy launch bounds the field time per period,
   // at the cost of a missed detection slot
   // Card detection launches only from idle; an underflow mid-sequence is not queued
   assign cd_launch = underflow & auto_card_detect & (cd_state_q == CD_IDLE);
   assign cd_found  = (cd_state_q == CD_RESULT) & card_result_valid & card_present;
   assign cd_empty  = (cd_state_q == CD_RESULT) & card_result_valid & !card_present;

   // Card detection sequence: field on while the third timer counts, then await the verdict
   always_comb begin
      cd_state_d = cd_state_q;
      case (cd_state_q)
         CD_IDLE: begin
            if (cd_launch) begin
               cd_state_d = CD_FIELD;
            end
         end
         CD_FIELD: begin
            if (third_timer_underflow) begin
               cd_state_d = CD_RESULT;
            end
         end
         CD_RESULT: begin
            if (card_result_valid) begin
               cd_state_d = CD_IDLE;
            end
         end
         default: begin
            cd_state_d = CD_IDLE;
         end
      endcase
   end

   // Events are one-cycle strobes; status turns them into levels
   // Interrupt sources
   assign irq_event[`IRQ_UNDERFLOW]    = underflow;
   assign irq_event[`IRQ_CARD_FOUND]   = cd_found;
   assign irq_event[`IRQ_DETECT_EMPTY] = cd_empty;
   assign irq_clear = wr_status ? hwdata[`IRQ_COUNT-1:0] : '0;

   // Writing back the value read clears only the events seen;
   // a newer event in the same cycle survives
   // Sticky status bits; a set in the clearing cycle wins so no event is lost
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_COUNT; gi = gi + 1) begin : g_status
         assign status_d[gi] = irq_event[gi] | (status_q[gi] & ~irq_clear[gi]);
      end
   endgenerate

   // Read mux uses next values so a read right after a write sees that write
   always_comb begin
      rd_value = 32'h0000_0000;
      if (is_reg(addr_idx, `IDX_T3_COUNT_HIGH)) begin
         rd_value[7:0] = third_timer_count[15:8];
      end else if (is_reg(addr_idx, `IDX_T3_COUNT_LOW)) begin
         rd_value[7:0] = third_timer_count[7:0];
      end else if (is_reg(addr_idx, `IDX_CONTROL)) begin
         rd_value[7:0] = {running_d, 1'b0, cfg_d};
      end else if (is_reg(addr_idx, `IDX_RELOAD_HIGH)) begin
         rd_value[7:0] = reload_d[15:8];
      end else if (is_reg(addr_idx, `IDX_RELOAD_LOW)) begin
         rd_value[7:0] = reload_d[7:0];
      end else if (is_reg(addr_idx, `IDX_COUNT_HIGH)) begin
         rd_value[7:0] = count_d[15:8];
      end else if (is_reg(addr_idx, `IDX_COUNT_LOW)) begin
         rd_value[7:0] = count_d[7:0];
      end else if (is_reg(addr_idx, `IDX_IRQ_STATUS)) begin
         rd_value[`IRQ_COUNT-1:0] = status_d;
      end else if (is_reg(addr_idx, `IDX_IRQ_MASK)) begin
         rd_value[`IRQ_COUNT-1:0] = mask_d;
      end
   end

   // Read data is captured at the address edge, so a count byte
   // shows the count when the read was issued; the two count
   // bytes come from separate reads and may straddle a tick
   // Bus phase registers; zero wait states, read data captured at the address edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         idx_q     <= 8'h00;
         wr_pend_q <= 1'b0;
         hrdata_q  <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_take & hwrite;
         if (addr_take) begin
            idx_q <= addr_idx;
         end
         if (addr_take & !hwrite) begin
            hrdata_q <= rd_value;
         end
      end
   end

   // Reload resets to zero, so a start with no reload written
   // underflows at the very first tick
   // Timer core registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         running_q <= 1'b0;
         cfg_q     <= `CONTROL_RESET;
         reload_q  <= `RELOAD_RESET;
         count_q   <= `RELOAD_RESET;
      end else begin
         running_q <= running_d;
         cfg_q     <= cfg_d;
         reload_q  <= reload_d;
         count_q   <= count_d;
      end
   end

   // Interrupt is built from next values, so it moves on the same edge
   // as a status or mask change, and cannot glitch on a bus write
   // Interrupt registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_q <= '0;
         mask_q   <= `MASK_RESET;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
         irq_q    <= |(status_d & mask_d);
      end
   end

   // Field follows the next state: it rises with the launch pulse
   // and falls the cycle after the third timer interval ends
   // Card detection state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cd_state_q <= CD_IDLE;
         rf_field_q <= 1'b0;
      end else begin
         cd_state_q <= cd_state_d;
         rf_field_q <= (cd_state_d == CD_FIELD);
      end
   end

   // Pulses are not stretched; receivers sample every cycle
   // Request pulses to the rest of the chip, one cycle each
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wake_up_req_q       <= 1'b0;
         trim_start_q        <= 1'b0;
         card_detect_start_q <= 1'b0;
         power_down_req_q    <= 1'b0;
      end else begin
         wake_up_req_q       <= underflow & auto_wake;
         trim_start_q        <= underflow & auto_trim;
         card_detect_start_q <= cd_launch;
         // Return to power-down only after an empty detection or a finished trim
         power_down_req_q    <= auto_wake & (cd_empty | trim_done);
      end
   end

   // Every response is OKAY; unmapped indices read zero
   // Outputs
   assign hrdata            = hrdata_q;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign wake_up_req       = wake_up_req_q;
   assign trim_start        = trim_start_q;
   assign card_detect_start = card_detect_start_q;
   assign rf_field_enable   = rf_field_q;
   assign power_down_req    = power_down_req_q;
   assign wake_timer_irq    = irq_q;
endmodule
`default_nettype wire

// >>> verif/wakeup_timer_block_monitor.sv
// Port-level checker for the wake-up timer block, attached by bind
`timescale 1ns/1ps
`default_nettype none
module wakeup_timer_block_monitor (
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   rst,
   // Register bus
   input wire logic                   hsel,
   input wire logic [31:0]            haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic                   hready,
   input wire logic [31:0]            hrdata,
   // Neighbour inputs
   input wire logic                   lfo_tick,
   input wire wake_timer_pkg::count_t third_timer_count,
   input wire logic                   third_timer_underflow,
   input wire logic                   card_result_valid,
   input wire logic                   card_present,
   input wire logic                   trim_done,
   // Requests
   input wire logic                   wake_up_req,
   input wire logic                   trim_start,
   input wire logic                   card_detect_start,
   input wire logic                   rf_field_enable,
   input wire logic                   power_down_req
);
   import wake_timer_pkg::*;

   // One domain, so one clock and one disable for all properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Read address phase taken for a given register index
   sequence s_rd(logic [7:0] idx);
      hsel && hready && htrans[1] && !hwrite && haddr[9:2] == idx;
   endsequence
   // Field on and the third timer ending its interval
   sequence s_field_end;
      rf_field_enable && third_timer_underflow;
   endsequence

   property p_third_high;
      s_rd(8'h21) |=> hrdata[7:0] == $past(third_timer_count[15:8]);
   endproperty
   a_third_high: assert property (p_third_high) else $error("third count high byte wrong");
   property p_third_low;
      s_rd(8'h22) |=> hrdata[7:0] == $past(third_timer_count[7:0]);
   endproperty
   a_third_low: assert property (p_third_low) else $error("third count low byte wrong");
   property p_byte_wide;
      hrdata[31:8] == 24'h0;
   endproperty
   a_byte_wide: assert property (p_byte_wide) else $error("read data above the byte");
   // Underflow needs an oscillator tick in the same cycle, and its request comes one cycle later; the prescaler adds no stage
   property p_wake_cause;
      wake_up_req |-> $past(lfo_tick) || $past(lfo_tick, 2) || $past(lfo_tick, 3);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake request without tick");
   property p_trim_cause;
      trim_start |-> $past(lfo_tick) || $past(lfo_tick, 2) || $past(lfo_tick, 3);
   endproperty
   a_trim_cause: assert property (p_trim_cause) else $error("trim start without tick");
   property p_detect_cause;
      card_detect_start |-> $past(lfo_tick) || $past(lfo_tick, 2) || $past(lfo_tick, 3);
   endproperty
   a_detect_cause: assert property (p_detect_cause) else $error("detection without tick");
   property p_field_on;
      card_detect_start |=> rf_field_enable;
   endproperty
   a_field_on: assert property (p_field_on) else $error("field not on after launch");
   property p_field_hold;
      rf_field_enable && !third_timer_underflow && !$past(third_timer_underflow) |=> rf_field_enable;
   endproperty
   a_field_hold: assert property (p_field_hold) else $error("field dropped early");
   property p_field_off;
      s_field_end |-> ##[1:2] !rf_field_enable;
   endproperty
   a_field_off: assert property (p_field_off) else $error("field stayed on");
   property p_power_down;
      power_down_req |-> $past(trim_done) || ($past(card_result_valid) && !$past(card_present));
   endproperty
   a_power_down: assert property (p_power_down) else $error("power-down without cause");
endmodule

bind wakeup_timer_block wakeup_timer_block_monitor mon (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hrdata, .lfo_tick, .third_timer_count, .third_timer_underflow, .card_result_valid,
   .card_present, .trim_done, .wake_up_req, .trim_start, .card_detect_start, .rf_field_enable, .power_down_req);
`default_nettype wire

// >>> verif/wakeup_timer_block_test.sv
// Self-checking bench for the wake-up timer block
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_consts.svh"
module wakeup_timer_block_test;
   import wake_timer_pkg::*;
   logic        ref_clk, rst, hsel, hwrite, lfo_tick, third_timer_underflow, card_result_valid;
   logic        card_present, trim_done, hreadyout, hresp, wake_up_req, trim_start, card_detect_start;
   logic        rf_field_enable, power_down_req, wake_timer_irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   count_t      third_timer_count;
   int          n_mismatch = 0, checks_done = 0, n_wake = 0, n_trim = 0, n_cds = 0, n_pdr = 0;

   wakeup_timer_block dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lfo_tick, .third_timer_count,
      .third_timer_underflow, .card_result_valid, .card_present, .trim_done, .wake_up_req,
      .trim_start, .card_detect_start, .rf_field_enable, .power_down_req, .wake_timer_irq);

   always #20 ref_clk = ~ref_clk;

   // Request pulses are counted here so no scenario can miss a one-cycle pulse
   always @(posedge ref_clk) begin
      n_wake += (wake_up_req === 1'b1);
      n_trim += (trim_start === 1'b1);
      n_cds += (card_detect_start === 1'b1);
      n_pdr += (power_down_req === 1'b1);
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_n(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single AHB-Lite transfer; the wait for hready is bounded
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 20) begin
         n_mismatch++;
         give_verdict();
      end
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      bus(idx, 1'b0, 8'h00);
      check8(rd[7:0], exp);
   endtask

   // Oscillator ticks two cycles apart, then a short settle
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge ref_clk);
         lfo_tick <= 1'b1;
         @(posedge ref_clk);
         lfo_tick <= 1'b0;
      end
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic strobe(input logic uf, input logic rv, input logic td);
      @(posedge ref_clk);
      third_timer_underflow <= uf;
      card_result_valid <= rv;
      trim_done <= td;
      @(posedge ref_clk);
      {third_timer_underflow, card_result_valid, trim_done} <= 3'h0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic t_regs;
      third_timer_count <= 16'hA5C3;
      rd_chk(`IDX_T3_COUNT_HIGH, 8'hA5);
      check8({6'h00, hreadyout, hresp}, 8'h02);
      rd_chk(`IDX_T3_COUNT_LOW, 8'hC3);
      rd_chk(`IDX_CONTROL, 8'h00);
      rd_chk(`IDX_RELOAD_HIGH, 8'h00);
      bus(`IDX_COUNT_HIGH, 1'b1, 8'h5A);
      rd_chk(`IDX_COUNT_HIGH, 8'h00);
      rd_chk(8'h3F, 8'h00);
   endtask

   task automatic t_oneshot;
      bus(`IDX_RELOAD_LOW, 1'b1, 8'h02);
      bus(`IDX_CONTROL, 1'b1, 8'hC0);
      rd_chk(`IDX_CONTROL, 8'h80);
      bus(`IDX_RELOAD_LOW, 1'b1, 8'h05);
      ticks(1);
      rd_chk(`IDX_COUNT_LOW, 8'h01);
      ticks(1);
      rd_chk(`IDX_IRQ_STATUS, 8'h00);
      ticks(1);
      rd_chk(`IDX_IRQ_STATUS, 8'h01);
      rd_chk(`IDX_CONTROL, 8'h00);
      rd_chk(`IDX_COUNT_LOW, 8'h00);
      bus(`IDX_IRQ_STATUS, 1'b1, 8'h01);
   endtask

   // Running bit moves only together with the write enable bit
   task automatic t_guard;
      bus(`IDX_RELOAD_HIGH, 1'b1, 8'h81);
      bus(`IDX_CONTROL, 1'b1, 8'h80);
      rd_chk(`IDX_CONTROL, 8'h00);
      bus(`IDX_CONTROL, 1'b1, 8'hC0);
      rd_chk(`IDX_COUNT_HIGH, 8'h81);
      rd_chk(`IDX_COUNT_LOW, 8'h05);
      bus(`IDX_CONTROL, 1'b1, 8'h08);
      rd_chk(`IDX_CONTROL, 8'h88);
      bus(`IDX_CONTROL, 1'b1, 8'h40);
      rd_chk(`IDX_CONTROL, 8'h00);
      ticks(2);
      rd_chk(`IDX_COUNT_LOW, 8'h05);
   endtask

   task automatic t_presc;
      int div [4] = '{1, 8, 16, 32};
      bus(`IDX_RELOAD_HIGH, 1'b1, 8'h00);
      bus(`IDX_RELOAD_LOW, 1'b1, 8'h03);
      for (int s = 0; s < 4; s++) begin
         bus(`IDX_CONTROL, 1'b1, {6'h30, s[1:0]});
         ticks(div[s] - 1);
         rd_chk(`IDX_COUNT_LOW, 8'h03);
         ticks(1);
         rd_chk(`IDX_COUNT_LOW, 8'h02);
         bus(`IDX_CONTROL, 1'b1, 8'h40);
      end
   endtask

   task automatic t_auto;
      bus(`IDX_RELOAD_LOW, 1'b1, 8'h01);
      bus(`IDX_IRQ_MASK, 1'b1, 8'h01);
      bus(`IDX_CONTROL, 1'b1, 8'hEC);
      ticks(2);
      check_n(n_trim, 1);
      check_n(n_wake, 1);
      check8({7'h0, wake_timer_irq}, 8'h01);
      rd_chk(`IDX_CONTROL, 8'hAC);
      rd_chk(`IDX_COUNT_LOW, 8'h01);
      bus(`IDX_IRQ_MASK, 1'b1, 8'h00);
      repeat (2) @(posedge ref_clk);
      check8({7'h0, wake_timer_irq}, 8'h00);
      bus(`IDX_IRQ_MASK, 1'b1, 8'h07);
      bus(`IDX_IRQ_STATUS, 1'b1, 8'h01);
      repeat (2) @(posedge ref_clk);
      check8({7'h0, wake_timer_irq}, 8'h00);
      bus(`IDX_CONTROL, 1'b1, 8'h40);
   endtask

   // Detection twice: empty field first, then a card present
   task automatic t_card;
      bus(`IDX_CONTROL, 1'b1, 8'hD4);
      ticks(2);
      check_n(n_cds, 1);
      check8({7'h0, rf_field_enable}, 8'h01);
      rd_chk(`IDX_CONTROL, 8'h94);
      rd_chk(`IDX_COUNT_LOW, 8'h01);
      strobe(1'b1, 1'b0, 1'b0);
      check8({7'h0, rf_field_enable}, 8'h00);
      strobe(1'b0, 1'b1, 1'b0);
      check_n(n_pdr, 1);
      rd_chk(`IDX_IRQ_STATUS, 8'h05);
      bus(`IDX_IRQ_STATUS, 1'b1, 8'h07);
      card_present <= 1'b1;
      ticks(2);
      check_n(n_cds, 2);
      strobe(1'b1, 1'b0, 1'b0);
      strobe(1'b0, 1'b1, 1'b0);
      check_n(n_pdr, 1);
      rd_chk(`IDX_IRQ_STATUS, 8'h03);
      check8({7'h0, wake_timer_irq}, 8'h01);
      strobe(1'b0, 1'b0, 1'b1);
      check_n(n_pdr, 2);
   endtask

   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {hsel, hwrite, lfo_tick, third_timer_underflow, card_result_valid, card_present, trim_done} = 7'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      third_timer_count = 16'h0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_oneshot();
      t_guard();
      t_presc();
      t_auto();
      t_card();
      give_verdict();
   end
endmodule
`default_nettype wire
